/* File: hdl/ttis_defs.vh */
// register offsets, field layouts and reset values of the trail trace interrupt status block
`ifndef TTIS_DEFS_VH
`define TTIS_DEFS_VH

// ************************************************************
// register offsets (word index; byte address is 4x)
// ************************************************************
`define TTIS_ADDR_W 12
`define TTIS_OFS_TU3_MISMATCH 12'hF22
`define TTIS_OFS_TU4_MISMATCH 12'hF23
`define TTIS_OFS_TU1_UNSTABLE 12'hF24
`define TTIS_OFS_TU2_UNSTABLE 12'hF25
`define TTIS_OFS_TU3_UNSTABLE 12'hF26
`define TTIS_OFS_TU4_UNSTABLE 12'hF27
`define TTIS_OFS_MISMATCH_EN 12'hF30
`define TTIS_OFS_UNSTABLE_EN 12'hF31
`define TTIS_OFS_MODE 12'hF32
`define TTIS_OFS_STATE 12'hF33

// ************************************************************
// field layout and reset values
// ************************************************************
`define TTIS_GROUPS 7
`define TTIS_DATA_W 8
`define TTIS_TRIBS 4
`define TTIS_MODE_TU3_BIT 7
`define TTIS_FLAGS_RESET 7'h00
`define TTIS_EN_RESET 28'h0000000
`define TTIS_TU12_RESET 7'h00

`endif

/* File: hdl/ttis_change_det.v */
// change detector: one-cycle event on every edge of a vector of status levels
`timescale 1ns/100ps
`default_nettype none
module ttis_change_det
#(
  parameter WIDTH = 28
)
(
  // clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // status levels and their change events
  input wire [WIDTH-1:0] level_i,
  output wire [WIDTH-1:0] change_o
);

  reg [WIDTH-1:0] last;
  reg primed;

  // no event on the first sample after reset: the old state is unknown
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      last <= {WIDTH{1'b0}};
      primed <= 1'b0;
    end
    else
    begin
      last <= level_i;
      primed <= 1'b1;
    end
  end

  assign change_o = primed ? (last ^ level_i) : {WIDTH{1'b0}};

endmodule
`default_nettype wire

/* File: hdl/ttis_flag_reg.v */
// one sticky flag register of seven group bits, cleared by a read
`timescale 1ns/100ps
`default_nettype none
module ttis_flag_reg
#(
  parameter WIDTH = 7
)
(
  // clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // events, bits that are inactive, and the clearing read
  input wire [WIDTH-1:0] event_i,
  input wire [WIDTH-1:0] inactive_i,
  input wire read_clear_i,
  output reg [WIDTH-1:0] flags_o
);

  // a new event in the clearing cycle survives the clear
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      flags_o <= {WIDTH{1'b0}};
    else
      flags_o <= ((read_clear_i ? {WIDTH{1'b0}} : flags_o) | event_i) & ~inactive_i;
  end

endmodule
`default_nettype wire

/* File: hdl/ttis_top.v */
// interrupt status flags of the receive trail trace monitor, with register port
//
// Summary of operation
// - a mismatch flag per group for the fourth tributary sits at bit n-1 of offset 0xF23.
// - reading a flag register clears its flags and so withdraws their interrupt.
// - every change of a third- or fourth-tributary mismatch state, rising or falling, sets its flag outside TU3 mode, except a TU12 group's fourth-tributary bit.
// - every change of a tributary's unstable state, rising or falling, sets its flag, except a bit inactive in TU3 mode or a TU12 group's fourth-tributary bit.
// - in TU3 mode the second to fourth tributary flag registers are inactive and read zero.
// - a group in TU12 operation has its fourth-tributary mismatch bit inactive, reading zero.
// - bit 0 of the first-tributary unstable register reports the single TU3 trace in TU3 mode.
// - mismatch flags set and hold whatever the mismatch interrupt enable is.
// - unstable flags set and hold whatever the unstable interrupt enable is.
// - four unstable flag registers at 0xF24 to 0xF27, seven group flags in bits 0 to 6.
// - bits 1 to 6 of the first-tributary unstable register report groups two to seven.
// - the third-tributary mismatch flags report group bit-plus-one.
// - an enabled mismatch flag raises the interrupt on match loss and on match return.
// - an enabled unstable flag raises the interrupt on instability and on return to stable.
//
// register map, word index
// F22 third-tributary mismatch flags, group g at bit g-1, read clears
// F23 fourth-tributary mismatch flags, same layout
// F24 first-tributary unstable flags; bit 0 is the single trace in TU3 mode
// F25 second-tributary unstable flags
// F26 third-tributary unstable flags
// F27 fourth-tributary unstable flags
// F30 mismatch interrupt enables, bit g-1 enables group g on every tributary
// F31 unstable interrupt enables, same layout
// F32 mode: bit 7 TU3 mode, bits 6:0 groups in TU12 operation
// F33 first-tributary mismatch state levels, read only
// flag registers ignore writes, and other addresses read zero
// interrupt pin: OR of every set flag whose enable bit is one
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "ttis_defs.vh"
module ttis_top
#(
  parameter GROUPS = 7,
  parameter TRIBS = 4
)
(
  // clock and reset
  input wire clock_i,
  input wire reset_n_i,
  // register port
  input wire [11:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  output reg [7:0] reg_rdata_o,
  // monitored state, bit (trib-1)*7 + (group-1); the single TU3 trace is on bit 0
  input wire [27:0] mismatch_state_i,
  input wire [27:0] unstable_state_i,
  // interrupt request
  output reg irq_o
);

  // ************************************************************
  // configuration registers
  // ************************************************************
  reg [27:0] mismatch_irq_enable;
  reg [27:0] instability_irq_enable;
  reg tu3_mode;
  reg [6:0] tu12_groups;

  function [7:0] pad7;
    input [6:0] v;
    begin
      pad7 = {1'b0, v};
    end
  endfunction

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function any_enabled;
    input [6:0] flags;
    input [6:0] enables;
    begin
      any_enabled = |(flags & enables);
    end
  endfunction

  // write strobes; flag registers have none, so writes to them are ignored
  wire wr_mode = reg_write_i && hit(reg_addr_i, `TTIS_OFS_MODE);
  wire wr_mm_en = reg_write_i && hit(reg_addr_i, `TTIS_OFS_MISMATCH_EN);
  wire wr_un_en = reg_write_i && hit(reg_addr_i, `TTIS_OFS_UNSTABLE_EN);

  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mismatch_irq_enable <= `TTIS_EN_RESET;
      instability_irq_enable <= `TTIS_EN_RESET;
      tu3_mode <= 1'b0;
      tu12_groups <= `TTIS_TU12_RESET;
    end
    else
    begin
      // one enable word is broadcast to all four tributaries of a group:
      // the 8-bit port cannot reach 28 enable bits one by one
      if (wr_mode)
      begin
        tu3_mode <= reg_wdata_i[`TTIS_MODE_TU3_BIT];
        tu12_groups <= reg_wdata_i[6:0];
      end
      if (wr_mm_en)
        mismatch_irq_enable <= {4{reg_wdata_i[6:0]}};
      if (wr_un_en)
        instability_irq_enable <= {4{reg_wdata_i[6:0]}};
    end
  end

  // ************************************************************
  // event detection
  // ************************************************************
  wire [27:0] mismatch_change;
  wire [27:0] unstable_change;

  // a flip of a level in either direction is one event
  ttis_change_det #(.WIDTH(GROUPS * TRIBS)) u_mismatch_det
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .level_i(mismatch_state_i),
    .change_o(mismatch_change)
  );

  ttis_change_det #(.WIDTH(GROUPS * TRIBS)) u_unstable_det
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .level_i(unstable_state_i),
    .change_o(unstable_change)
  );

  // ************************************************************
  // read-clear strobes
  // ************************************************************
  // a read clears its register at the same edge that latches the data
  wire rd_mm3 = reg_read_i && hit(reg_addr_i, `TTIS_OFS_TU3_MISMATCH);
  wire rd_mm4 = reg_read_i && hit(reg_addr_i, `TTIS_OFS_TU4_MISMATCH);
  wire rd_un1 = reg_read_i && hit(reg_addr_i, `TTIS_OFS_TU1_UNSTABLE);
  wire rd_un2 = reg_read_i && hit(reg_addr_i, `TTIS_OFS_TU2_UNSTABLE);
  wire rd_un3 = reg_read_i && hit(reg_addr_i, `TTIS_OFS_TU3_UNSTABLE);
  wire rd_un4 = reg_read_i && hit(reg_addr_i, `TTIS_OFS_TU4_UNSTABLE);

  // ************************************************************
  // events and inactive masks per register
  // ************************************************************
  // tributary t of group g is state bit (t-1)*7 + (g-1)
  wire [6:0] tu3_mm_event = mismatch_change[20:14];
  wire [6:0] tu4_mm_event = mismatch_change[27:21];
  wire [6:0] tu1_un_event = unstable_change[6:0];
  wire [6:0] tu2_un_event = unstable_change[13:7];
  wire [6:0] tu3_un_event = unstable_change[20:14];
  wire [6:0] tu4_un_event = unstable_change[27:21];
  wire [6:0] off_all = {7{tu3_mode}};
  // in TU3 mode only bit 0 lives, carrying the single trace
  wire [6:0] off_tu1 = {{6{tu3_mode}}, 1'b0};
  // a group in TU12 operation has no fourth tributary
  wire [6:0] off_tu4 = off_all | tu12_groups;

  // ************************************************************
  // sticky flag registers
  // ************************************************************
  wire [6:0] tu3_mm_flags;
  wire [6:0] tu4_mm_flags;
  wire [6:0] tu1_un_flags;
  wire [6:0] tu2_un_flags;
  wire [6:0] tu3_un_flags;
  wire [6:0] tu4_un_flags;

  // flags ignore the enables entirely so software can poll
  ttis_flag_reg #(.WIDTH(GROUPS)) u_tu3_mm
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .event_i(tu3_mm_event),
    .inactive_i(off_all),
    .read_clear_i(rd_mm3),
    .flags_o(tu3_mm_flags)
  );

  ttis_flag_reg #(.WIDTH(GROUPS)) u_tu4_mm
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .event_i(tu4_mm_event),
    .inactive_i(off_tu4),
    .read_clear_i(rd_mm4),
    .flags_o(tu4_mm_flags)
  );

  ttis_flag_reg #(.WIDTH(GROUPS)) u_tu1_un
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .event_i(tu1_un_event),
    .inactive_i(off_tu1),
    .read_clear_i(rd_un1),
    .flags_o(tu1_un_flags)
  );

  ttis_flag_reg #(.WIDTH(GROUPS)) u_tu2_un
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .event_i(tu2_un_event),
    .inactive_i(off_all),
    .read_clear_i(rd_un2),
    .flags_o(tu2_un_flags)
  );

  ttis_flag_reg #(.WIDTH(GROUPS)) u_tu3_un
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .event_i(tu3_un_event),
    .inactive_i(off_all),
    .read_clear_i(rd_un3),
    .flags_o(tu3_un_flags)
  );

  ttis_flag_reg #(.WIDTH(GROUPS)) u_tu4_un
  (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .event_i(tu4_un_event),
    .inactive_i(off_tu4),
    .read_clear_i(rd_un4),
    .flags_o(tu4_un_flags)
  );

  // ************************************************************
  // read data and interrupt
  // ************************************************************
  reg [7:0] next_rdata;

  always @*
  begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      `TTIS_OFS_TU3_MISMATCH: next_rdata = pad7(tu3_mm_flags);
      `TTIS_OFS_TU4_MISMATCH: next_rdata = pad7(tu4_mm_flags);
      `TTIS_OFS_TU1_UNSTABLE: next_rdata = pad7(tu1_un_flags);
      `TTIS_OFS_TU2_UNSTABLE: next_rdata = pad7(tu2_un_flags);
      `TTIS_OFS_TU3_UNSTABLE: next_rdata = pad7(tu3_un_flags);
      `TTIS_OFS_TU4_UNSTABLE: next_rdata = pad7(tu4_un_flags);
      `TTIS_OFS_MISMATCH_EN: next_rdata = pad7(mismatch_irq_enable[6:0]);
      `TTIS_OFS_UNSTABLE_EN: next_rdata = pad7(instability_irq_enable[6:0]);
      `TTIS_OFS_MODE: next_rdata = {tu3_mode, tu12_groups};
      `TTIS_OFS_STATE: next_rdata = pad7(mismatch_state_i[6:0]);
      default: next_rdata = 8'h00;
    endcase
  end

  // read data stand for one cycle only, zero otherwise
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= reg_read_i ? next_rdata : 8'h00;
  end

  // ************************************************************
  // interrupt
  // ************************************************************
  // first and second tributary mismatch flags are not held here, so their enables go unused
  wire [6:0] tu3_mm_en = mismatch_irq_enable[20:14];
  wire [6:0] tu4_mm_en = mismatch_irq_enable[27:21];
  wire [6:0] tu1_un_en = instability_irq_enable[6:0];
  wire [6:0] tu2_un_en = instability_irq_enable[13:7];
  wire [6:0] tu3_un_en = instability_irq_enable[20:14];
  wire [6:0] tu4_un_en = instability_irq_enable[27:21];
  wire mm_pending = any_enabled(tu3_mm_flags, tu3_mm_en)
                    | any_enabled(tu4_mm_flags, tu4_mm_en);
  wire un_pending = any_enabled(tu1_un_flags, tu1_un_en)
                    | any_enabled(tu2_un_flags, tu2_un_en)
                    | any_enabled(tu3_un_flags, tu3_un_en)
                    | any_enabled(tu4_un_flags, tu4_un_en);
  wire next_irq = mm_pending | un_pending;

  // registered so the pin cannot glitch while flags and enables change
  always @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= next_irq;
  end

endmodule
`default_nettype wire

/* File: sim/ttis_top_sva.sv */
// assertion checker for the trail trace interrupt status block
`timescale 1ns/100ps
`default_nettype none
module ttis_top_sva
#(
  parameter GROUPS = 7,
  parameter TRIBS = 4
)
(
  // clock, reset and register port
  input wire clock_i,
  input wire reset_n_i,
  input wire [11:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_write_i,
  input wire reg_read_i,
  input wire [7:0] reg_rdata_o,
  // status and interrupt
  input wire [27:0] mismatch_state_i,
  input wire [27:0] unstable_state_i,
  input wire irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // shadow of the mode word, so reads can be judged against it
  logic [7:0] mode;
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i) mode <= 8'h00;
    else if (reg_write_i && reg_addr_i == 12'hF32) mode <= reg_wdata_i;
  property p_idle; !reg_read_i |=> reg_rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  property p_unmapped;
    reg_read_i && (reg_addr_i < 12'hF22 || (reg_addr_i > 12'hF27 && reg_addr_i < 12'hF30))
    |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole read not zero");
  property p_clear;
    (reg_read_i && reg_addr_i == 12'hF23 && $stable(mismatch_state_i))
    ##1 $stable(mismatch_state_i) ##1 (reg_read_i && reg_addr_i == 12'hF23)
    |=> reg_rdata_o == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("flags kept after read");
  property p_irq_fall;
    $fell(irq_o) |-> $past(reg_read_i, 2) || $past(reg_read_i) || $past(reg_write_i, 2)
    || $past(reg_write_i);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
  property p_tu3_off;
    reg_read_i && $past(mode[7]) && reg_addr_i >= 12'hF25 && reg_addr_i <= 12'hF27
    |=> reg_rdata_o == 8'h00;
  endproperty
  a_tu3_off: assert property (p_tu3_off) else $error("tu3 mode flag set");
  property p_tu12_off;
    reg_read_i && reg_addr_i == 12'hF23 |=> (reg_rdata_o[6:0] & $past(mode[6:0], 2)) == 7'h00;
  endproperty
  a_tu12_off: assert property (p_tu12_off) else $error("tu12 group flag set");
  property p_mm4;
    !mode[7] && !mode[0] && !reg_write_i && $changed(mismatch_state_i[21])
    ##1 (!reg_write_i && !(reg_read_i && reg_addr_i == 12'hF23))[*3]
    ##1 (reg_read_i && reg_addr_i == 12'hF23) |=> reg_rdata_o[0];
  endproperty
  a_mm4: assert property (p_mm4) else $error("tu4 mismatch not flagged");
  property p_mm3;
    !mode[7] && !reg_write_i && $changed(mismatch_state_i[20])
    ##1 (!reg_write_i && !(reg_read_i && reg_addr_i == 12'hF22))[*3]
    ##1 (reg_read_i && reg_addr_i == 12'hF22) |=> reg_rdata_o[6];
  endproperty
  a_mm3: assert property (p_mm3) else $error("tu3 mismatch not flagged");
  property p_un1;
    $changed(unstable_state_i[0]) ##1 (!(reg_read_i && reg_addr_i == 12'hF24))[*3]
    ##1 (reg_read_i && reg_addr_i == 12'hF24) |=> reg_rdata_o[0];
  endproperty
  a_un1: assert property (p_un1) else $error("unstable not flagged");
  c_irq: cover property ($rose(irq_o));
  c_irq_read: cover property (irq_o && reg_read_i);
  c_tu3_read: cover property (reg_read_i && mode[7]);
endmodule
bind ttis_top ttis_top_sva #(.GROUPS(GROUPS), .TRIBS(TRIBS)) ttis_top_sva_inst (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_rdata_o(reg_rdata_o), .mismatch_state_i(mismatch_state_i),
  .unstable_state_i(unstable_state_i), .irq_o(irq_o));
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench of the trail trace interrupt status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [27:0] mismatch_state_i = 28'h0000000;
  logic [27:0] unstable_state_i = 28'h0000000;
  wire [7:0] reg_rdata_o;
  wire irq_o;
  int num_errors = 0;
  int num_checks = 0;
  always #10 clock_i = ~clock_i;
  ttis_top ttis_top_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .mismatch_state_i(mismatch_state_i),
    .unstable_state_i(unstable_state_i), .irq_o(irq_o));
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so look just past that edge
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask
  // flip status levels, then allow flag and irq to settle
  task automatic tog(input logic [27:0] m, input logic [27:0] u);
    @(posedge clock_i);
    mismatch_state_i <= mismatch_state_i ^ m;
    unstable_state_i <= unstable_state_i ^ u;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 6; a++) rd(12'(12'hF22 + a), 8'h00);
    rd(12'hF2C, 8'h00);
    `CHK(irq_o, 1'b0)
    $display("reset test done");
    tog(28'hFFFC000, 28'h0);
    `CHK(irq_o, 1'b0)
    rd(12'hF23, 8'h7F);
    rd(12'hF23, 8'h00);
    rd(12'hF22, 8'h7F);
    tog(28'hFFFC000, 28'h0);
    rd(12'hF22, 8'h7F);
    rd(12'hF23, 8'h7F);
    $display("mismatch test done");
    tog(28'h0, 28'hFFFFFFF);
    `CHK(irq_o, 1'b0)
    for (int t = 0; t < 4; t++) rd(12'(12'hF24 + t), 8'h7F);
    for (int t = 0; t < 4; t++) rd(12'(12'hF24 + t), 8'h00);
    $display("unstable test done");
    wr(12'hF30, 8'h01);
    rd(12'hF30, 8'h01);
    tog(28'h0200000, 28'h0);
    `CHK(irq_o, 1'b1)
    rd(12'hF23, 8'h01);
    repeat (2) @(posedge clock_i);
    #1 `CHK(irq_o, 1'b0)
    tog(28'h0200000, 28'h0);
    `CHK(irq_o, 1'b1)
    rd(12'hF23, 8'h01);
    wr(12'hF31, 8'h01);
    rd(12'hF31, 8'h01);
    tog(28'h0, 28'h0000080);
    `CHK(irq_o, 1'b1)
    wr(12'hF31, 8'h00);
    repeat (2) @(posedge clock_i);
    #1 `CHK(irq_o, 1'b0)
    rd(12'hF25, 8'h01);
    $display("interrupt test done");
    wr(12'hF32, 8'h01);
    tog(28'hFE00000, 28'h0);
    rd(12'hF23, 8'h7E);
    wr(12'hF32, 8'h80);
    rd(12'hF32, 8'h80);
    tog(28'hFFFFFFF, 28'hFFFFFFF);
    for (int t = 1; t < 4; t++) rd(12'(12'hF24 + t), 8'h00);
    rd(12'hF24, 8'h01);
    rd(12'hF22, 8'h00);
    rd(12'hF23, 8'h00);
    rd(12'hF33, 8'h7F);
    $display("mode test done");
    report_and_stop();
  end
  // cut a hang short well past the 120 or so cycles the tests need
  initial
  begin
    #100000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
